/* File: rtl/pulse_timer_pkg.sv */
/*
 * Package for the pulse port timer and compare block: register offsets,
 * field positions, reset values, command codes, modes and tick timing.
 * Assumes a 200 MHz module clock and a 32-bit classic Wishbone bus.
 */
package pulse_timer_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_COMMAND      = 8'h00;
	localparam logic [7:0] OFF_ARGUMENT     = 8'h04;
	localparam logic [7:0] OFF_MODE         = 8'h08;
	localparam logic [7:0] OFF_STATUS       = 8'h0c;
	localparam logic [7:0] OFF_P1_LOW       = 8'h10;
	localparam logic [7:0] OFF_P1_HIGH      = 8'h14;
	localparam logic [7:0] OFF_P2_LOW       = 8'h18;
	localparam logic [7:0] OFF_P2_HIGH      = 8'h1c;
	localparam logic [7:0] OFF_P1_TARGET    = 8'h20;
	localparam logic [7:0] OFF_P2_TARGET    = 8'h24;
	localparam logic [7:0] OFF_P1_RANGE_LO  = 8'h28;
	localparam logic [7:0] OFF_P1_RANGE_HI  = 8'h2c;
	localparam logic [7:0] OFF_P2_RANGE_LO  = 8'h30;
	localparam logic [7:0] OFF_P2_RANGE_HI  = 8'h34;
	localparam logic [7:0] OFF_PATTERN      = 8'h38;
	localparam logic [7:0] OFF_RANGE_STATUS = 8'h3c;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CMD_SEL_LSB     = 0;
	localparam int CMD_CTRL_LSB    = 16;
	localparam int ARG_ONTIME_LSB  = 0;
	localparam int ARG_ONTIME_W    = 20;
	localparam int ARG_UNIT_LSB    = 20;
	localparam int MODE_P2_LSB     = 4;
	localparam int MODE_CYCLE_BIT  = 8;
	localparam int PATTERN_P2_LSB  = 16;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] RST_ARGUMENT = 32'h0000_0000;
	localparam logic [2:0]  RST_MODE     = 3'h0;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [15:0] SEL_ONESHOT_P1 = 16'h0001;
	localparam logic [15:0] SEL_ONESHOT_P2 = 16'h0002;
	localparam logic [15:0] SEL_MEASURE_P1 = 16'h000b;
	localparam logic [15:0] SEL_MEASURE_P2 = 16'h000c;
	localparam logic [15:0] CTRL_START     = 16'h0000;
	localparam logic [15:0] CTRL_STOP      = 16'h0001;

	// ****************************************************************
	// Port operation modes and time units
	// ****************************************************************
	typedef enum logic [2:0] {
		MODE_RELATIVE    = 3'h0,
		MODE_ONESHOT     = 3'h1,
		MODE_MEASURE     = 3'h2,
		MODE_INDEPENDENT = 3'h3,
		MODE_LINEAR      = 3'h4,
		MODE_CIRCULAR    = 3'h5,
		MODE_CAM         = 3'h6
	} port_mode_t;

	typedef enum logic [1:0] {
		UNIT_10US  = 2'h0,
		UNIT_100US = 2'h1,
		UNIT_1MS   = 2'h2
	} time_unit_t;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int UNIT_10US_PS  = 10000000;
	localparam int UNIT_100US_PS = 100000000;
	localparam int UNIT_1MS_PS   = 1000000000;
	localparam int CYC_10US      = UNIT_10US_PS / CLK_PERIOD_PS;
	localparam int CYC_100US     = UNIT_100US_PS / CLK_PERIOD_PS;
	localparam int CYC_1MS       = UNIT_1MS_PS / CLK_PERIOD_PS;

endpackage

/* File: rtl/tick_if.sv */
/*
 * Interface carrying the three time-unit ticks from the tick divider
 * to the port logic. Assumes both ends run on the same module clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface tick_if;
	logic tick_10us;
	logic tick_100us;
	logic tick_1ms;

	modport source (output tick_10us, output tick_100us, output tick_1ms);
	modport sink   (input tick_10us, input tick_100us, input tick_1ms);
endinterface

`default_nettype wire

/* File: rtl/tick_divider.sv */
/*
 * Divider making one-cycle ticks at 0.01 ms, 0.1 ms and 1 ms from the
 * module clock. Assumes the periods given are at least two cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
	parameter int P_10US  = pulse_timer_pkg::CYC_10US,
	parameter int P_100US = pulse_timer_pkg::CYC_100US,
	parameter int P_1MS   = pulse_timer_pkg::CYC_1MS
) (
	input  wire logic  mclk,
	input  wire logic  rst,
	tick_if.source     ticks
);

	logic [31:0] cnt_10us;
	logic [31:0] cnt_100us;
	logic [31:0] cnt_1ms;

	// ****************************************************************
	// Free-running dividers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_10us  <= 32'h0000_0000;
			cnt_100us <= 32'h0000_0000;
			cnt_1ms   <= 32'h0000_0000;
		end else begin
			cnt_10us  <= (cnt_10us == 32'(P_10US - 1)) ? 32'h0 :
				cnt_10us + 32'h1;
			cnt_100us <= (cnt_100us == 32'(P_100US - 1)) ? 32'h0 :
				cnt_100us + 32'h1;
			cnt_1ms   <= (cnt_1ms == 32'(P_1MS - 1)) ? 32'h0 :
				cnt_1ms + 32'h1;
		end
	end

	assign ticks.tick_10us  = (cnt_10us == 32'(P_10US - 1));
	assign ticks.tick_100us = (cnt_100us == 32'(P_100US - 1));
	assign ticks.tick_1ms   = (cnt_1ms == 32'(P_1MS - 1));

endmodule // tick_divider

`default_nettype wire

/* File: rtl/pulse_port_timer.sv */
/*
 * Pulse port timer and compare block: one-shot pulses, elapsed-time
 * measurement, target and range compare on the pulse output present
 * value, and speed-change cycle selection, behind a Wishbone slave.
 * Assumes the pulse generator, present values, busy flags, ramp command
 * strobe and I/O refresh strobe come from logic on mclk.
 */
// What this block does
// - One-shot drives port output ON for programmed 0.01 to 9999 ms, then OFF.
// - One-shot output turns ON within 0.2 ms of the command.
// - Selector 000B or 000C with control 0000 starts the elapsed timer.
// - Selector 000B or 000C with control 0001 stops the elapsed timer.
// - Start clears 32-bit count, count rises with time, holds on stop.
// - Count spans 32 bits, low half first word, high half second word.
// - Count unit selectable as 0.01 ms, 0.1 ms or 1 ms.
// - Measurement mode suppresses the port's external pulse output.
// - Measurement port performs no other pulse output function.
// - Start while running clears count and restarts at once.
// - Status words take the count only at the I/O refresh.
// - Present value reaching target raises a compare event in linear or circular mode.
// - No compare events in independent, one-shot or cam modes.
// - Pattern bits set while present value lies inside range.
// - One 1 ms or 2 ms speed cycle shared by both ports and ramps.
// - Cycle select bit clear gives 2 ms, set gives 1 ms.
// - Ramp commands issued during pulse output keep the old cycle.
// - One-shot count clears at ON, rises until OFF, then holds.
`timescale 1ns/10ps
`default_nettype none

module pulse_port_timer #(
	parameter int CYC_100US = pulse_timer_pkg::CYC_100US,
	parameter int CYC_1MS   = pulse_timer_pkg::CYC_1MS
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  pulse_gen,
	input  wire logic [1:0]  pulse_busy,
	input  wire logic [31:0] present_count_value_1,
	input  wire logic [31:0] present_count_value_2,
	input  wire logic        ramped_speed_issue,
	input  wire logic        io_refresh,
	output logic      [1:0]  pulse_out,
	output logic      [1:0]  compare_event,
	output logic             speed_cycle_1ms
);

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_ONESHOT = 3'b010,
		ST_MEASURE = 3'b100
	} port_state_t;

	tick_if ticks ();

	logic [31:0]   argument;
	logic [2:0]    mode [2];
	logic          cycle_select;
	logic [31:0]   target [2];
	logic [31:0]   range_lo [2];
	logic [31:0]   range_hi [2];
	logic [15:0]   pattern [2];
	logic [15:0]   range_bits [2];
	port_state_t   state [2];
	logic [1:0]    unit [2];
	logic [19:0]   ontime [2];
	logic [31:0]   count [2];
	logic [31:0]   elapsed [2];
	logic [31:0]   pv [2];
	logic [31:0]   pv_prev [2];
	logic          wr_stb;
	logic          rd_stb;
	logic          cmd_stb;
	logic [15:0]   cmd_sel;
	logic [15:0]   cmd_ctrl;
	logic [31:0]   next_rdata;

	assign pv[0] = present_count_value_1;
	assign pv[1] = present_count_value_2;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic unit_tick(input logic [1:0] u,
		input logic t10, input logic t100, input logic t1000);
		case (u)
			pulse_timer_pkg::UNIT_10US:  unit_tick = t10;
			pulse_timer_pkg::UNIT_100US: unit_tick = t100;
			pulse_timer_pkg::UNIT_1MS:   unit_tick = t1000;
			default:                     unit_tick = t1000;
		endcase
	endfunction

	function automatic logic in_window(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		in_window = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic compare_allowed(input logic [2:0] m);
		compare_allowed = (m == pulse_timer_pkg::MODE_LINEAR) ||
			(m == pulse_timer_pkg::MODE_CIRCULAR);
	endfunction

	// ****************************************************************
	// Tick divider
	// ****************************************************************
	tick_divider #(
		.P_10US  (pulse_timer_pkg::CYC_10US),
		.P_100US (CYC_100US),
		.P_1MS   (CYC_1MS)
	) u_ticks (
		.mclk  (mclk),
		.rst   (rst),
		.ticks (ticks.source)
	);

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	assign wr_stb   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign rd_stb   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign cmd_stb  = wr_stb && (wb_adr_i == pulse_timer_pkg::OFF_COMMAND);
	assign cmd_sel  = wb_dat_i[pulse_timer_pkg::CMD_SEL_LSB +: 16];
	assign cmd_ctrl = wb_dat_i[pulse_timer_pkg::CMD_CTRL_LSB +: 16];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			pulse_timer_pkg::OFF_ARGUMENT:  next_rdata = argument;
			pulse_timer_pkg::OFF_MODE: begin
				next_rdata[2:0] = mode[0];
				next_rdata[pulse_timer_pkg::MODE_P2_LSB +: 3] = mode[1];
				next_rdata[pulse_timer_pkg::MODE_CYCLE_BIT] = cycle_select;
			end
			pulse_timer_pkg::OFF_STATUS: begin
				next_rdata[1:0] = pulse_out;
				next_rdata[2]   = (state[0] == ST_MEASURE);
				next_rdata[3]   = (state[1] == ST_MEASURE);
				next_rdata[4]   = speed_cycle_1ms;
			end
			pulse_timer_pkg::OFF_P1_LOW:  next_rdata = {16'h0, elapsed[0][15:0]};
			pulse_timer_pkg::OFF_P1_HIGH: next_rdata = {16'h0, elapsed[0][31:16]};
			pulse_timer_pkg::OFF_P2_LOW:  next_rdata = {16'h0, elapsed[1][15:0]};
			pulse_timer_pkg::OFF_P2_HIGH: next_rdata = {16'h0, elapsed[1][31:16]};
			pulse_timer_pkg::OFF_P1_TARGET:   next_rdata = target[0];
			pulse_timer_pkg::OFF_P2_TARGET:   next_rdata = target[1];
			pulse_timer_pkg::OFF_P1_RANGE_LO: next_rdata = range_lo[0];
			pulse_timer_pkg::OFF_P1_RANGE_HI: next_rdata = range_hi[0];
			pulse_timer_pkg::OFF_P2_RANGE_LO: next_rdata = range_lo[1];
			pulse_timer_pkg::OFF_P2_RANGE_HI: next_rdata = range_hi[1];
			pulse_timer_pkg::OFF_PATTERN: next_rdata = {pattern[1], pattern[0]};
			pulse_timer_pkg::OFF_RANGE_STATUS:
				next_rdata = {range_bits[1], range_bits[0]};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= pulse_timer_pkg::RST_WORD;
		end else if (rd_stb) begin
			wb_dat_o <= next_rdata;
		end else begin
			wb_dat_o <= pulse_timer_pkg::RST_WORD;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			argument     <= pulse_timer_pkg::RST_ARGUMENT;
			mode[0]      <= pulse_timer_pkg::RST_MODE;
			mode[1]      <= pulse_timer_pkg::RST_MODE;
			cycle_select <= 1'b0;
		end else if (wr_stb) begin
			if (wb_adr_i == pulse_timer_pkg::OFF_ARGUMENT) begin
				argument <= merge(argument, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == pulse_timer_pkg::OFF_MODE && wb_sel_i[0]) begin
				mode[0] <= wb_dat_i[2:0];
				mode[1] <= wb_dat_i[pulse_timer_pkg::MODE_P2_LSB +: 3];
			end
			if (wb_adr_i == pulse_timer_pkg::OFF_MODE && wb_sel_i[1]) begin
				cycle_select <= wb_dat_i[pulse_timer_pkg::MODE_CYCLE_BIT];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < 2; p++) begin
				target[p]   <= pulse_timer_pkg::RST_WORD;
				range_lo[p] <= pulse_timer_pkg::RST_WORD;
				range_hi[p] <= pulse_timer_pkg::RST_WORD;
				pattern[p]  <= 16'h0000;
			end
		end else if (wr_stb) begin
			case (wb_adr_i)
				pulse_timer_pkg::OFF_P1_TARGET:
					target[0] <= merge(target[0], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_P2_TARGET:
					target[1] <= merge(target[1], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_P1_RANGE_LO:
					range_lo[0] <= merge(range_lo[0], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_P1_RANGE_HI:
					range_hi[0] <= merge(range_hi[0], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_P2_RANGE_LO:
					range_lo[1] <= merge(range_lo[1], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_P2_RANGE_HI:
					range_hi[1] <= merge(range_hi[1], wb_dat_i, wb_sel_i);
				pulse_timer_pkg::OFF_PATTERN: begin
					if (wb_sel_i[0]) pattern[0][7:0]  <= wb_dat_i[7:0];
					if (wb_sel_i[1]) pattern[0][15:8] <= wb_dat_i[15:8];
					if (wb_sel_i[2]) pattern[1][7:0]  <= wb_dat_i[23:16];
					if (wb_sel_i[3]) pattern[1][15:8] <= wb_dat_i[31:24];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Port timers
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < 2; p++) begin
				state[p]  <= ST_IDLE;
				unit[p]   <= pulse_timer_pkg::UNIT_10US;
				ontime[p] <= 20'h00000;
				count[p]  <= 32'h0000_0000;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				logic tk;
				logic fire;
				logic start;
				logic stop;
				tk    = unit_tick(unit[p], ticks.tick_10us,
					ticks.tick_100us, ticks.tick_1ms);
				fire  = cmd_stb && mode[p] == pulse_timer_pkg::MODE_ONESHOT &&
					cmd_sel == (p == 0 ? pulse_timer_pkg::SEL_ONESHOT_P1 :
					pulse_timer_pkg::SEL_ONESHOT_P2) &&
					argument[pulse_timer_pkg::ARG_ONTIME_LSB +:
					pulse_timer_pkg::ARG_ONTIME_W] != 20'h0;
				start = cmd_stb && mode[p] == pulse_timer_pkg::MODE_MEASURE &&
					cmd_sel == (p == 0 ? pulse_timer_pkg::SEL_MEASURE_P1 :
					pulse_timer_pkg::SEL_MEASURE_P2) &&
					cmd_ctrl == pulse_timer_pkg::CTRL_START;
				stop  = cmd_stb && mode[p] == pulse_timer_pkg::MODE_MEASURE &&
					cmd_sel == (p == 0 ? pulse_timer_pkg::SEL_MEASURE_P1 :
					pulse_timer_pkg::SEL_MEASURE_P2) &&
					cmd_ctrl == pulse_timer_pkg::CTRL_STOP;
				if (fire || start) begin
					state[p]  <= fire ? ST_ONESHOT : ST_MEASURE;
					unit[p]   <= argument[pulse_timer_pkg::ARG_UNIT_LSB +: 2];
					ontime[p] <= argument[pulse_timer_pkg::ARG_ONTIME_LSB +:
						pulse_timer_pkg::ARG_ONTIME_W];
					count[p]  <= 32'h0000_0000;
				end else begin
					case (state[p])
						ST_ONESHOT: begin
							if (mode[p] != pulse_timer_pkg::MODE_ONESHOT) begin
								state[p] <= ST_IDLE;
							end else if (tk) begin
								count[p] <= count[p] + 32'h1;
								if (count[p] + 32'h1 >= {12'h0, ontime[p]}) begin
									state[p] <= ST_IDLE;
								end
							end
						end
						ST_MEASURE: begin
							if (stop ||
								mode[p] != pulse_timer_pkg::MODE_MEASURE) begin
								state[p] <= ST_IDLE;
							end else if (tk && count[p] != 32'hffff_ffff) begin
								count[p] <= count[p] + 32'h1;
							end
						end
						ST_IDLE: begin
						end
						default: state[p] <= ST_IDLE;
					endcase
				end
			end
		end
	end

	// Status words follow the count only at refresh
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			elapsed[0] <= pulse_timer_pkg::RST_WORD;
			elapsed[1] <= pulse_timer_pkg::RST_WORD;
		end else if (io_refresh) begin
			elapsed[0] <= count[0];
			elapsed[1] <= count[1];
		end
	end

	// ****************************************************************
	// Pulse outputs
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pulse_out <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				case (mode[p])
					pulse_timer_pkg::MODE_MEASURE:
						pulse_out[p] <= 1'b0;
					pulse_timer_pkg::MODE_ONESHOT:
						pulse_out[p] <= (state[p] == ST_ONESHOT);
					default:
						pulse_out[p] <= pulse_gen[p];
				endcase
			end
		end
	end

	// ****************************************************************
	// Target and range compare
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			compare_event <= 2'b00;
			for (int p = 0; p < 2; p++) begin
				pv_prev[p]    <= 32'h0000_0000;
				range_bits[p] <= 16'h0000;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				pv_prev[p] <= pv[p];
				compare_event[p] <= compare_allowed(mode[p]) &&
					pv[p] == target[p] && pv_prev[p] != target[p];
				range_bits[p] <= in_window(pv[p], range_lo[p], range_hi[p]) ?
					pattern[p] : 16'h0000;
			end
		end
	end

	// ****************************************************************
	// Speed-change cycle
	// ****************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			speed_cycle_1ms <= 1'b0;
		end else if (ramped_speed_issue && pulse_busy == 2'b00) begin
			speed_cycle_1ms <= cycle_select;
		end
	end

endmodule // pulse_port_timer

`default_nettype wire

/* File: tb/pulse_port_timer_properties.sv */
/*
 * Checker for the pulse port timer: bus answer, compare events,
 * speed cycle select and the quiet measuring port.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/10ps
`default_nettype none

module pulse_port_timer_properties (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [1:0]  pulse_gen,
	input wire logic [1:0]  pulse_busy,
	input wire logic [31:0] present_count_value_1,
	input wire logic [31:0] present_count_value_2,
	input wire logic        ramped_speed_issue,
	input wire logic        io_refresh,
	input wire logic [1:0]  pulse_out,
	input wire logic [1:0]  compare_event,
	input wire logic        speed_cycle_1ms
);
	// ****************************************************************
	// Mode shadow and properties
	// ****************************************************************
	logic [8:0] mode_seen;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			mode_seen <= 9'h000;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
			&& wb_adr_i == 8'h08)
			mode_seen <= wb_dat_i[8:0];
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_cycle_hold: assert property (
		(!ramped_speed_issue || pulse_busy != 2'h0)
		|=> $stable(speed_cycle_1ms))
		else $error("cycle select moved");
	chk_cycle_latch: assert property (
		(ramped_speed_issue && pulse_busy == 2'h0)
		|=> speed_cycle_1ms == $past(mode_seen[8]))
		else $error("cycle select not taken");
	chk_event_single: assert property (
		compare_event[0] |=> !compare_event[0])
		else $error("event longer than one cycle");
	chk_event_cause: assert property (
		compare_event[0] |-> $past(present_count_value_1, 2)
		!= $past(present_count_value_1))
		else $error("event without value change");
	chk_event_mode: assert property (
		compare_event[0] |-> $past(mode_seen[2:0]) inside {3'h4, 3'h5})
		else $error("event in wrong mode");
	chk_measure_quiet: assert property (
		(mode_seen[2:0] == 3'h2) [*3] |-> !pulse_out[0])
		else $error("measuring port drives output");

	cover property (compare_event[0]);
	cover property (ramped_speed_issue && pulse_busy != 2'h0);
	cover property (mode_seen[2:0] == 3'h1 && pulse_out[0]);
endmodule // pulse_port_timer_properties

bind pulse_port_timer pulse_port_timer_properties u_chk (
	.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.pulse_gen(pulse_gen), .pulse_busy(pulse_busy),
	.present_count_value_1(present_count_value_1),
	.present_count_value_2(present_count_value_2),
	.ramped_speed_issue(ramped_speed_issue), .io_refresh(io_refresh),
	.pulse_out(pulse_out), .compare_event(compare_event),
	.speed_cycle_1ms(speed_cycle_1ms));

`default_nettype wire

/* File: tb/tb.sv */
/*
 * Self-checking bench for the pulse port timer.
 * Assumes short 0.1 ms and 1 ms tick parameters (the 0.01 ms tick keeps its 2000-cycle default) and a 200 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
	// ****************************************************************
	// Stimulus and checking
	// ****************************************************************
	typedef struct {logic [31:0] lo; logic [31:0] hi;} span_t;
	logic        mclk, rst, cyc, stb, we, ack, ramp, refr, c1ms;
	logic [7:0]  adr;
	logic [31:0] dwr, drd, pv1, pv2;
	logic [1:0]  gen, busy, pout, cev;
	span_t       q[$];
	span_t       cur;
	int          err_total, comparisons, events, n, p, per;
	int          seed = 23722;
	int          per_tab[3] = '{2000, 20, 200};
	logic [2:0]  mtab[5] = '{3'h4, 3'h3, 3'h5, 3'h1, 3'h6};
	int          etab[5] = '{1, 1, 2, 2, 2};

	pulse_port_timer #(.CYC_100US(20), .CYC_1MS(200)) DUT (
		.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dwr),
		.wb_dat_o(drd), .wb_ack_o(ack), .pulse_gen(gen),
		.pulse_busy(busy), .present_count_value_1(pv1),
		.present_count_value_2(pv2), .ramped_speed_issue(ramp),
		.io_refresh(refr), .pulse_out(pout), .compare_event(cev),
		.speed_cycle_1ms(c1ms));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic report_and_stop;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, lo, hi);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: got %h", $time, got);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dwr <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (ack !== 1'b1) begin
			cmp(32'h0, 32'h1, 32'h1);
			report_and_stop();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] lo, hi);
		q.push_back('{lo, hi});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic refresh;
		refr <= 1'b1;
		@(posedge mclk);
		refr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic ramp_issue;
		ramp <= 1'b1;
		@(posedge mclk);
		ramp <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	always @(posedge mclk) begin
		gen <= 2'($random(seed));
		pv2 <= 32'($random(seed));
		if (cev[0] === 1'b1)
			events++;
		if (ack === 1'b1 && we === 1'b0) begin
			cur = q.pop_front();
			cmp(drd, cur.lo, cur.hi);
		end
	end

	initial begin
		{rst, cyc, stb, we, ramp, refr, adr, dwr, pv1, busy} = '0;
		rst = 1'b1;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int i = 1; i < 17; i++)
			if (i != 3)
				rd(8'(4 * i), 32'h0, 32'h0);
		for (int u = 0; u < 3; u++) begin
			p = u % 2;
			per = per_tab[u];
			wr_mode(p ? 32'h20 : 32'h2);
			bus(1'b1, 8'h04, 32'(u) << 20);
			bus(1'b1, 8'h00, p ? 32'hc : 32'hb);
			repeat (5 * per) @(posedge mclk);
			bus(1'b1, 8'h00, p ? 32'hc : 32'hb);
			repeat (2 * per) @(posedge mclk);
			bus(1'b1, 8'h00, p ? 32'h1000c : 32'h1000b);
			rd(p ? 8'h18 : 8'h10, u / 2, u == 2 ? 3 : 0);
			refresh();
			rd(p ? 8'h18 : 8'h10, 32'h1, 32'h3);
			rd(p ? 8'h1c : 8'h14, 32'h0, 32'h0);
		end
		wr_mode(32'h1);
		bus(1'b1, 8'h04, 32'h0010_0005);
		bus(1'b1, 8'h00, 32'h1);
		for (n = 0; pout[0] !== 1'b1 && n < 40; n++) @(posedge mclk);
		cmp(32'(n), 32'h0, 32'd39);
		if (n == 40)
			report_and_stop();
		for (n = 0; pout[0] === 1'b1 && n < 200; n++) @(posedge mclk);
		cmp(32'(n), 32'd75, 32'd101);
		if (n == 200)
			report_and_stop();
		refresh();
		rd(8'h10, 32'h4, 32'h5);
		bus(1'b1, 8'h20, 32'd100);
		bus(1'b1, 8'h28, 32'd95);
		bus(1'b1, 8'h2c, 32'd105);
		bus(1'b1, 8'h38, 32'ha5);
		for (int i = 0; i < 5; i++) begin
			wr_mode({29'h0, mtab[i]});
			for (int v = 90; v < 111; v++) begin
				pv1 <= 32'(v);
				@(posedge mclk);
			end
			repeat (2) @(posedge mclk);
			cmp(32'(events), etab[i], etab[i]);
		end
		pv1 <= 32'd100;
		@(posedge mclk);
		rd(8'h3c, 32'ha5, 32'ha5);
		wr_mode(32'h100);
		ramp_issue();
		cmp({31'h0, c1ms}, 32'h1, 32'h1);
		wr_mode(32'h0);
		busy <= 2'b01;
		ramp_issue();
		cmp({31'h0, c1ms}, 32'h1, 32'h1);
		busy <= 2'b00;
		ramp_issue();
		cmp({31'h0, c1ms}, 32'h0, 32'h0);
		report_and_stop();
	end

	task automatic wr_mode(input logic [31:0] m);
		bus(1'b1, 8'h08, m);
	endtask
endmodule // tb

`default_nettype wire
